// *** rtl/dcs_pkg.sv ***
// Constants and types for the DDR3 command and clock-enable state control
package dcs_pkg;

  // Pin widths and bank count
  localparam int BA_W   = 3;
  localparam int ADDR_W = 13;
  localparam int NBANK  = 8;

  // Address bit positions
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int BL_BIT = 0;

  // Mode register 0 burst-length field value for on-the-fly selection
  localparam logic [1:0] BL_OTF = 2'h1;

  // Mode register index for burst-length field
  localparam logic [2:0] MR_BURST = 3'h0;

  // Timing counts in clock cycles, and the width of the counter that holds them
  localparam int BURST_BEATS_BL8 = 4;
  localparam int BURST_BEATS_BC4 = 2;
  localparam int PRE_CYC         = 4;
  localparam int REF_CYC         = 16;
  localparam int ZQ_CYC          = 8;
  localparam int MRD_CYC         = 4;
  localparam int XS_CYC          = 8;
  localparam int XP_CYC          = 3;
  localparam int CNT_W           = 8;

  // Reset values
  localparam logic [1:0] MR0_BL_RST = 2'h0;

  // Decoded commands
  typedef enum logic [11:0] {
    CMD_DES  = 12'h001,
    CMD_NOP  = 12'h002,
    CMD_MRS  = 12'h004,
    CMD_REF  = 12'h008,
    CMD_PRE  = 12'h010,
    CMD_PREA = 12'h020,
    CMD_ACT  = 12'h040,
    CMD_WR   = 12'h080,
    CMD_RD   = 12'h100,
    CMD_ZQCL = 12'h200,
    CMD_ZQCS = 12'h400,
    CMD_ILL  = 12'h800
  } dcs_cmd_t;

  // Device states
  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_ACTIVE = 10'h002,
    ST_READ   = 10'h004,
    ST_WRITE  = 10'h008,
    ST_PRECH  = 10'h010,
    ST_REFR   = 10'h020,
    ST_PPD    = 10'h040,
    ST_APD    = 10'h080,
    ST_SREF   = 10'h100,
    ST_BUSY   = 10'h200
  } dcs_state_t;

endpackage

// *** rtl/dcs_decode.sv ***
// Command decoder from the sampled strobes and address bits
`timescale 1ns/1ps
`default_nettype none

module dcs_decode
  import dcs_pkg::*;
(
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic              ap,
  output dcs_pkg::dcs_cmd_t      cmd
);

  // -----------------------------------------------------------------
  // Strobe truth table
  // -----------------------------------------------------------------
  // standard strobe encodings
  always_comb
  begin
    if (cs_n)
      cmd = CMD_DES;
    else
    begin
      case ({ras_n, cas_n, we_n})
        3'h0:    cmd = CMD_MRS;
        3'h1:    cmd = CMD_REF;
        3'h2:    cmd = ap ? CMD_PREA : CMD_PRE;
        3'h3:    cmd = CMD_ACT;
        3'h4:    cmd = CMD_WR;
        3'h5:    cmd = CMD_RD;
        3'h6:    cmd = ap ? CMD_ZQCL : CMD_ZQCS;
        3'h7:    cmd = CMD_NOP;
        default: cmd = CMD_ILL;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** rtl/dcs_ctrl.sv ***
// Command interpreter and clock-enable power-state tracker
`timescale 1ns/1ps
`default_nettype none

module dcs_ctrl
  import dcs_pkg::*;
#(
  parameter int NUM_BANKS = NBANK
)
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     cke,
  input  wire logic                     cs_n,
  input  wire logic                     ras_n,
  input  wire logic                     cas_n,
  input  wire logic                     we_n,
  input  wire logic                     odt,
  input  wire logic [dcs_pkg::BA_W-1:0] ba,
  input  wire logic [dcs_pkg::ADDR_W-1:0] addr,
  output logic      [9:0]               state,
  output logic      [NUM_BANKS-1:0]     bank_open,
  output logic                          burst_active,
  output logic                          odt_enable,
  output logic                          refresh_allowed,
  output logic                          illegal_cmd,
  output logic                          sref_active
);

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  logic [6:1]        sync1_r;
  logic [6:1]        sync2_r;
  logic              sref_req_r;
  logic              sref_wake_r;
  logic              wake1_r;
  logic              wake2_r;
  logic [BA_W-1:0]   ba1_r;
  logic [BA_W-1:0]   ba2_r;
  logic [ADDR_W-1:0] ad1_r;
  logic [ADDR_W-1:0] ad2_r;

  // Pins come from the controller's domain; two flops each
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= 6'h0F;  // Strobes idle high: deselect
      sync2_r <= 6'h0F;
      wake1_r <= 1'b0;
      wake2_r <= 1'b0;
      ba1_r   <= '0;
      ba2_r   <= '0;
      ad1_r   <= '0;
      ad2_r   <= '0;
    end
    else
    begin
      sync1_r <= {odt, cke, cs_n, ras_n, cas_n, we_n};
      sync2_r <= sync1_r;
      wake1_r <= sref_wake_r;
      wake2_r <= wake1_r;
      ba1_r   <= ba;
      ba2_r   <= ba1_r;
      ad1_r   <= addr;
      ad2_r   <= ad1_r;
    end
  end

  wire logic odt_s = sync2_r[6];
  wire logic cke_s = sync2_r[5];

  // -----------------------------------------------------------------
  // Asynchronous self-refresh exit detect
  // -----------------------------------------------------------------
  // exit without clock
  // The raw CKE rise sets the flag even while the clock is stopped
  always_ff @(posedge cke or negedge reset_n)
  begin
    if (!reset_n)
      sref_wake_r <= 1'b0;
    else
      sref_wake_r <= sref_req_r;
  end

  // -----------------------------------------------------------------
  // Command decode
  // -----------------------------------------------------------------
  dcs_cmd_t cmd;
  dcs_decode u_dec
  (
    .cs_n  (sync2_r[4]),
    .ras_n (sync2_r[3]),
    .cas_n (sync2_r[2]),
    .we_n  (sync2_r[1]),
    .ap    (ad2_r[AP_BIT]),
    .cmd   (cmd)
  );

  // NOP and deselect are both harmless fillers
  function automatic logic is_quiet(input dcs_cmd_t c);
    is_quiet = (c == CMD_NOP) || (c == CMD_DES);
  endfunction

  // -----------------------------------------------------------------
  // State registers
  // -----------------------------------------------------------------
  dcs_state_t        st_r;
  dcs_state_t        st_nxt;
  logic              cke_prev_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [NUM_BANKS-1:0] open_r;
  logic [NUM_BANKS-1:0] open_nxt;
  logic [1:0]        mr_bl_r;
  logic              ill_nxt;
  logic              auto_pre_r;
  logic              auto_pre_nxt;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mr_bl_r <= MR0_BL_RST;
    else if (cke_prev_r && cke_s && st_r == ST_IDLE && cmd == CMD_MRS && ba2_r == MR_BURST)
      mr_bl_r <= ad2_r[BL_BIT+1:BL_BIT];
  end

  // Burst beats: on-the-fly mode reads the chop bit per command
  logic [CNT_W-1:0] burst_cyc;
  assign burst_cyc = (mr_bl_r == BL_OTF && !ad2_r[BC_BIT]) ? CNT_W'(BURST_BEATS_BC4) : CNT_W'(BURST_BEATS_BL8);

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  // judge from both CKE, state, command
  always_comb
  begin
    st_nxt       = st_r;
    cnt_nxt      = (cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
    open_nxt     = open_r;
    ill_nxt      = 1'b0;
    auto_pre_nxt = auto_pre_r;
    case (st_r)
      ST_PPD, ST_APD:
      begin
        if (!cke_prev_r && cke_s)
        begin
          ill_nxt = !is_quiet(cmd);
          st_nxt  = ST_BUSY;
          cnt_nxt = CNT_W'(XP_CYC);
        end
      end
      ST_SREF:
      begin
        if (wake2_r && cke_s)
        begin
          ill_nxt = !is_quiet(cmd);
          st_nxt  = ST_BUSY;
          cnt_nxt = CNT_W'(XS_CYC);
        end
      end
      default:
      begin
        if (cke_prev_r && !cke_s)
        begin
          if (cmd == CMD_REF && st_r == ST_IDLE && cnt_r == '0)
            st_nxt = ST_SREF;
          else if (!is_quiet(cmd))
            ill_nxt = 1'b1;
          // idle or refreshing to precharge power-down
          else if (st_r == ST_IDLE || st_r == ST_REFR)
            st_nxt = ST_PPD;
          // choose by banks open after command
          else if (open_r == '0 || (auto_pre_r && st_r != ST_ACTIVE))
            st_nxt = ST_PPD;
          else
            st_nxt = ST_APD;
          if (st_nxt != st_r)
          begin
            cnt_nxt = '0;
            if (st_nxt == ST_PPD)
              open_nxt = '0;
          end
        end
        else if (!cke_s)
          ill_nxt = 1'b0;
        else if (is_quiet(cmd))
        begin
          if (cnt_r == CNT_W'(1) || (cnt_r == '0 && st_r != ST_IDLE && st_r != ST_ACTIVE))
          begin
            open_nxt     = auto_pre_r ? '0 : open_r;
            auto_pre_nxt = 1'b0;
            st_nxt       = (open_nxt == '0) ? ST_IDLE : ST_ACTIVE;
          end
        end
        else if (cnt_r != '0 || st_r == ST_REFR || st_r == ST_BUSY)
          ill_nxt = 1'b1;
        else
        begin
          case (cmd)
            CMD_ACT:
            begin
              open_nxt[ba2_r] = 1'b1;
              st_nxt = ST_ACTIVE;
            end
            CMD_RD, CMD_WR:
            begin
              if (!open_r[ba2_r])
                ill_nxt = 1'b1;
              else
              begin
                st_nxt       = (cmd == CMD_RD) ? ST_READ : ST_WRITE;
                cnt_nxt      = burst_cyc;
                auto_pre_nxt = ad2_r[AP_BIT];
                if (ad2_r[AP_BIT])
                  open_nxt[ba2_r] = 1'b0;
              end
            end
            CMD_PRE, CMD_PREA:
            begin
              open_nxt = (cmd == CMD_PREA) ? '0 : open_r & ~(NUM_BANKS'(1) << ba2_r);
              st_nxt  = ST_PRECH;
              cnt_nxt = CNT_W'(PRE_CYC);
            end
            CMD_REF, CMD_MRS, CMD_ZQCL, CMD_ZQCS:
            begin
              if (st_r != ST_IDLE)
                ill_nxt = 1'b1;
              else if (cmd == CMD_REF)
              begin
                st_nxt  = ST_REFR;
                cnt_nxt = CNT_W'(REF_CYC);
              end
              else
              begin
                st_nxt  = ST_BUSY;
                cnt_nxt = (cmd == CMD_MRS) ? CNT_W'(MRD_CYC) : CNT_W'(ZQ_CYC);
              end
            end
            default: ill_nxt = 1'b1;
          endcase
        end
      end
    endcase
  end

  // Registered state and bookkeeping
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r       <= ST_IDLE;
      cke_prev_r <= 1'b0;
      cnt_r      <= '0;
      open_r     <= '0;
      auto_pre_r <= 1'b0;
      sref_req_r <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      cke_prev_r <= cke_s;
      cnt_r      <= cnt_nxt;
      open_r     <= open_nxt;
      auto_pre_r <= auto_pre_nxt;
      sref_req_r <= (st_nxt == ST_SREF);
    end
  end

  // -----------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------
  // no refresh in power-down
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state           <= 10'h001;
      bank_open       <= '0;
      burst_active    <= 1'b0;
      odt_enable      <= 1'b0;
      refresh_allowed <= 1'b0;
      illegal_cmd     <= 1'b0;
      sref_active     <= 1'b0;
    end
    else
    begin
      state           <= st_nxt;
      bank_open       <= open_nxt;
      burst_active    <= (st_nxt == ST_READ || st_nxt == ST_WRITE) && cnt_nxt != '0;
      odt_enable      <= odt_s && st_nxt != ST_SREF;
      refresh_allowed <= st_nxt == ST_SREF || st_nxt == ST_REFR;
      illegal_cmd     <= ill_nxt;
      sref_active     <= st_nxt == ST_SREF;
    end
  end

endmodule
`default_nettype wire

// *** verif/dcs_ctrl_properties.sv ***
// Port-level timing checks of the power-state tracker
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_chk
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic [9:0] state,
  input wire logic       burst_active,
  input wire logic       odt_enable,
  input wire logic       refresh_allowed,
  input wire logic       illegal_cmd,
  input wire logic       sref_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Either power-down flavour
  wire logic pd = state[6] | state[7];
  // Pins reach the state three samples late, so cke history is read at depth 2 and 3
  sequence s_beat;
    burst_active [*2];
  endsequence
  sequence s_xs;
    state[9] [*8];
  endsequence
  sequence s_xp;
    state[9] [*3];
  endsequence
  property p_burst;
    $rose(burst_active) |-> s_beat ##[1:3] !burst_active;
  endproperty
  property p_srx;
    $fell(state[8]) |-> s_xs ##1 state[0];
  endproperty
  property p_pdx;
    $fell(state[7]) |-> s_xp ##1 state[1];
  endproperty
  property p_pd_hold;
    pd && !$past(cke, 2) |=> pd;
  endproperty
  property p_pde;
    state[0] && $past(cke, 3) && !$past(cke, 2) && $past(cs_n, 2) |=> state[6];
  endproperty
  property p_sre;
    $rose(state[8]) |-> $past(state[0]);
  endproperty
  property p_odt;
    sref_active && $past(sref_active) |-> !odt_enable;
  endproperty
  property p_pd_ref;
    pd |-> !refresh_allowed;
  endproperty
  property p_ill;
    illegal_cmd |=> !illegal_cmd;
  endproperty
  a_burst: assert property (p_burst) else $error("burst length wrong");
  a_srx: assert property (p_srx) else $error("self refresh exit timing wrong");
  a_pdx: assert property (p_pdx) else $error("power down exit timing wrong");
  a_pd_hold: assert property (p_pd_hold) else $error("power down left with cke low");
  a_pde: assert property (p_pde) else $error("idle power down not entered");
  a_sre: assert property (p_sre) else $error("self refresh entered from non idle");
  a_odt: assert property (p_odt) else $error("termination on in self refresh");
  a_pd_ref: assert property (p_pd_ref) else $error("refresh during power down");
  a_ill: assert property (p_ill) else $error("illegal flag too long");
endmodule
`default_nettype wire

// *** verif/dcs_host_model.sv ***
// Controller-side driver of the command and clock-enable pins
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model
  import dcs_pkg::*;
(
  input  wire logic                      clk,
  output var logic                       cke  = 1'b1,
  output var logic                       cs_n = 1'b1,
  output var logic                       ras_n = 1'b1,
  output var logic                       cas_n = 1'b1,
  output var logic                       we_n = 1'b1,
  output var logic                       odt  = 1'b0,
  output var logic [dcs_pkg::BA_W-1:0]   ba   = '0,
  output var logic [dcs_pkg::ADDR_W-1:0] addr = '0
);
  logic              req = 1'b0;
  logic              k   = 1'b1;
  logic              o   = 1'b0;
  logic [3:0]        c   = 4'hF;
  logic [BA_W-1:0]   b   = '0;
  logic [ADDR_W-1:0] a   = '0;
  // One command for exactly one edge; the caller spaces cke changes
  // cke hold and quiet edges
  task automatic put(input logic [3:0] cc, input logic [BA_W-1:0] bb, input logic [ADDR_W-1:0] aa,
                     input logic kk);
    @(negedge clk);
    c = cc;
    b = bb;
    a = aa;
    k = kk;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask
  // Pins launch on the rising edge; deselected lines churn so stale values never help
  // deselect with churn
  always @(posedge clk)
  begin
    cke <= k;
    odt <= o;
    if (req)
      {cs_n, ras_n, cas_n, we_n, ba, addr} <= {c, b, a};
    else
    begin
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'($urandom);
      ba <= BA_W'($urandom);
      addr <= ADDR_W'($urandom);
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the command and power-state tracker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb;
  import dcs_pkg::*;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [BA_W-1:0]  ba;
  logic [ADDR_W-1:0] addr;
  logic [9:0]       state, last = ST_IDLE, exp_s;
  logic [7:0]       bank_open;
  logic             burst_active, odt_enable, refresh_allowed, illegal_cmd, sref_active;
  logic [BA_W-1:0]  bk;
  logic [9:0]       q[$];
  int               fails = 0, checks = 0, beats = 0, bad = 0;
  dcs_ctrl dut (.clk, .reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .ba, .addr, .state, .bank_open,
                .burst_active, .odt_enable, .refresh_allowed, .illegal_cmd, .sref_active);
  dcs_host_model m (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .ba, .addr);
  // Free-running 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  // Each state change takes the oldest noted state; a change with none noted is a fault
  always @(posedge clk)
  begin
    if (burst_active === 1'b1)
      beats++;
    if (illegal_cmd === 1'b1)
      bad++;
    if (reset_n === 1'b1 && state !== last)
    begin
      exp_s = (q.size() > 0) ? q.pop_front() : last;
      `CHK(state, exp_s)
    end
    last = state;
  end
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic drain;
    for (int i = 0; i < 60 && q.size() > 0; i++)
      @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // Note the states the command should walk through, send it, then wait them out
  task automatic go(input logic [3:0] c, input logic [ADDR_W-1:0] a, input logic k, input logic [9:0] e1, e2);
    q.push_back(e1);
    if (e2 !== 10'h000)
      q.push_back(e2);
    m.put(c, bk, a, k);
    drain();
  endtask
  // Hang guard, well past the expected few hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    summarize();
  end
  // Main sequence; commands {cs,ras,cas,we}
  initial
  begin
    void'($urandom(23));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(state, ST_IDLE)
    `CHK(bank_open, 8'h00)
    bk = BA_W'($urandom);
    go(4'h3, ADDR_W'($urandom), 1'b1, ST_ACTIVE, 10'h000);
    `CHK(bank_open, 8'h01 << bk)
    beats = 0;
    go(4'h5, 13'h0000, 1'b1, ST_READ, ST_ACTIVE);
    `CHK(beats, BURST_BEATS_BL8)
    beats = 0;
    go(4'h4, 13'h1000, 1'b1, ST_WRITE, ST_ACTIVE);
    `CHK(beats, BURST_BEATS_BL8)
    $display("test activate read done");
    go(4'h7, 13'h0000, 1'b0, ST_APD, 10'h000);
    `CHK(refresh_allowed, 1'b0)
    go(4'h7, 13'h0000, 1'b1, ST_BUSY, ST_ACTIVE);
    go(4'h2, 13'h0400, 1'b1, ST_PRECH, ST_IDLE);
    `CHK(bank_open, 8'h00)
    $display("test active power down done");
    m.o = 1'b1;
    repeat (5) @(posedge clk);
    `CHK(odt_enable, 1'b1)
    go(4'h1, 13'h0000, 1'b0, ST_SREF, 10'h000);
    `CHK(odt_enable, 1'b0)
    `CHK(refresh_allowed, 1'b1)
    `CHK(sref_active, 1'b1)
    q.push_back(ST_BUSY);
    q.push_back(ST_IDLE);
    // Activate inside the exit window on purpose: refused and flagged
    m.put(4'h7, bk, 13'h0000, 1'b1);
    m.put(4'h3, bk, 13'h0000, 1'b1);
    drain();
    `CHK(bad, 1)
    `CHK(bank_open, 8'h00)
    $display("test self refresh done");
    // Deselect at entry so the idle entry check sees it
    go(4'hF, 13'h0000, 1'b0, ST_PPD, 10'h000);
    go(4'h7, 13'h0000, 1'b1, ST_BUSY, ST_IDLE);
    `CHK(q.size(), 0)
    $display("test precharge power down done");
    // Mode set to bank 0 selects on-the-fly length; chop bit low gives short burst
    bk = '0;
    go(4'h0, 13'h0001, 1'b1, ST_BUSY, ST_IDLE);
    go(4'h1, 13'h0000, 1'b1, ST_REFR, ST_IDLE);
    go(4'h3, 13'h0000, 1'b1, ST_ACTIVE, 10'h000);
    beats = 0;
    go(4'h5, 13'h0400, 1'b1, ST_READ, ST_IDLE);
    `CHK(beats, BURST_BEATS_BC4)
    `CHK(bank_open, 8'h00)
    $display("test chopped read done");
    summarize();
  end
endmodule
bind dcs_ctrl dcs_ctrl_chk u_chk (.clk, .reset_n, .cke, .cs_n, .state, .burst_active, .odt_enable,
                                  .refresh_allowed, .illegal_cmd, .sref_active);
`default_nettype wire
